// ---- design/tes_cause.sv ----
// Combines raw trap conditions into trap-type flags.
// Assumes condition inputs are synchronous to aclk and valid with trap qualification.
`timescale 1ns/1ps
module tes_cause (
   input  wire logic               opcode_cond,
   input  wire logic               overflow_check_op,
   input  wire logic               overflow_flag,
   input  wire logic               lock_violation,
   input  wire logic               external_irq_pin,
   input  wire logic               irq_gate_bit,
   input  wire logic               fetch_xlate_fault,
   input  wire logic               operand_xlate_fault,
   input  wire logic               operand_misaligned,
   input  wire logic               operand_valid,
   input  wire logic [31:0]        operand_addr,
   input  wire logic [31:0]        watch_address_reg,
   input  wire logic               watch_enable,
   input  wire logic               float_exception,
   input  wire logic               float_trap_allow,
   output tes_pkg::tes_cause_t     cause
);
   logic watch_hit;

   assign watch_hit = operand_valid && watch_enable && (operand_addr == watch_address_reg);

   always_comb begin
      cause          = '0;
      cause.opcode   = opcode_cond || (overflow_check_op && overflow_flag) || lock_violation;
      cause.external = external_irq_pin && irq_gate_bit;
      cause.fetch    = fetch_xlate_fault;
      // Three separate causes share one flag
      cause.operand  = operand_xlate_fault || operand_misaligned || watch_hit;
      cause.float_t  = float_exception && float_trap_allow;
      cause.locked   = lock_violation;
      cause.overflow = overflow_check_op && overflow_flag;
   end
endmodule

// ---- design/tes_map.svh ----
// Offsets, field positions, reset values and constants of the trap entry sequencer.
// Assumes a 32-bit AXI4-Lite register port with word-aligned byte addresses.
`ifndef TES_MAP_SVH
`define TES_MAP_SVH

`define TES_OFF_STATUS   12'h000
`define TES_OFF_EXT      12'h004
`define TES_OFF_FAULT    12'h008
`define TES_OFF_FSTAT    12'h00C
`define TES_OFF_ENTRY    12'h010
`define TES_OFF_WATCH    12'h014
`define TES_OFF_CTRL     12'h018

// Processor status fields
`define TES_ST_PRIV      0
`define TES_ST_SPRIV     1
`define TES_ST_IRQ       2
`define TES_ST_SIRQ      3
`define TES_ST_DUALT     4
`define TES_ST_TOGGLE    5
`define TES_ST_SKIPF     6
`define TES_ST_OPC       8
`define TES_ST_EXT       9
`define TES_ST_FETCH     10
`define TES_ST_OPER      11
`define TES_ST_FLOAT     12
`define TES_ST_MASK      32'h00001F7F
// Extended status fields
`define TES_EX_LOCKED    0
`define TES_EX_OVF       1
`define TES_EX_MASK      32'h00000003
// Float status field
`define TES_FS_ALLOW     0
// Page root field
`define TES_PR_BUSHOLD   0

`define TES_RST_STATUS   32'h00000001
`define TES_RST_FSTAT    32'h00000001
`define TES_HANDLER_VA   32'hFFFFFF00
`define TES_HALF_STEP    32'h00000004
`define TES_ENTRY_CYC    2

`endif

// ---- design/tes_pkg.sv ----
// Types shared by the trap entry sequencer files.
// Assumes the constants header is included by users of these types.
package tes_pkg;
   typedef enum logic [1:0] {
      TES_RUN   = 2'b00,
      TES_ABORT = 2'b01,
      TES_SAVE  = 2'b10,
      TES_FETCH = 2'b11
   } tes_state_t;

   typedef struct packed {
      logic opcode;
      logic external;
      logic fetch;
      logic operand;
      logic float_t;
      logic locked;
      logic overflow;
   } tes_cause_t;
endpackage

// ---- design/tes_sequencer.sv ----
// Trap entry sequencer: aborts, saves status, records causes and vectors to the handler.
// Assumes the pipeline supplies per-cycle trap conditions, mode and instruction addresses,
// and that software reaches status over AXI4-Lite on aclk.
`timescale 1ns/1ps
`include "tes_map.svh"

// How it works
// - Any non-reset trap aborts the current instruction, leaving it restartable.
// - Entry copies privilege into saved privilege, irq gate into saved gate.
// - Then privilege and irq gate are cleared: supervisor, interrupts off.
// - Dual-at-trap bit set if in dual mode, else cleared.
// - Toggle bit set when a mode switch was pending at the trap.
// - Every present trap-type flag is set, several together if coincident.
// - Single mode: fault address is the trapped instruction address.
// - Dual mode: fault address is the float half; core half at plus 4.
// - Lone operand fault in dual mode completes the float half first.
// - Entry releases the bus hold output.
// - Handler fetch starts at virtual address FFFFFF00.
// - Handler runs in single-instruction mode whatever the prior mode.
// - Fault address read once per trap; next capture waits for that read.
// - Indirect branch uses trap behaviour while any trap-type flag other than overflow is set.
// - Skip-next-float may stay set from dual mode; it kills next float op.
// - No float traps while float trap allow is cleared.
// - External interrupt pin assertion traps and sets external event flag only while the irq gate bit is set.
// - Translation, misalignment and watch matches all set operand fault flag.
// - Overflow check with overflow flag set raises an instruction trap.
module tes_sequencer (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Pipeline side
   input  wire logic        opcode_cond,
   input  wire logic        overflow_check_op,
   input  wire logic        lock_violation,
   input  wire logic        external_irq_pin,
   input  wire logic        fetch_xlate_fault,
   input  wire logic        operand_xlate_fault,
   input  wire logic        operand_misaligned,
   input  wire logic        operand_valid,
   input  wire logic [31:0] operand_addr,
   input  wire logic        float_exception,
   input  wire logic        overflow_set,
   input  wire logic        dual_mode,
   input  wire logic        next_dual,
   input  wire logic        float_half_done,
   input  wire logic [31:0] instr_addr,
   input  wire logic        bus_hold_req,
   input  wire logic        indirect_branch,
   input  wire logic        float_issue,
   output logic             abort_instr,
   output logic             complete_float_half,
   output logic             fetch_req,
   output logic [31:0]      fetch_addr,
   output logic             single_mode_force,
   output logic             trap_branch_mode,
   output logic             kill_float,
   output logic             bus_hold_n,
   output logic             user_mode,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      tes_pkg::tes_state_t state;
      logic [31:0] status;
      logic [31:0] ext;
      logic [31:0] fault;
      logic        fault_armed;
      logic [31:0] fstat;
      logic [31:0] entry;
      logic [31:0] watch;
      logic        watch_en;
      logic [6:0]  pend;
      logic        pend_dual;
      logic        pend_toggle;
      logic [31:0] pend_addr;
      logic        abort;
      logic        complete_fh;
      logic        fetch;
      logic [31:0] faddr;
      logic        single;
      logic        tbr;
      logic        kill;
      logic        hold_n;
      logic        user;
      logic        awr;
      logic        wr;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        aw_got;
      logic        w_got;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arr;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tes_regs_t;

   tes_regs_t           r_reg;
   tes_regs_t           r_next;
   tes_pkg::tes_cause_t cause;
   logic                any_trap;
   logic                any_flag;

   tes_cause u_cause (
      .opcode_cond         (opcode_cond),
      .overflow_check_op   (overflow_check_op),
      .overflow_flag       (r_reg.ext[`TES_EX_OVF]),
      .lock_violation      (lock_violation),
      .external_irq_pin    (external_irq_pin),
      .irq_gate_bit        (r_reg.status[`TES_ST_IRQ]),
      .fetch_xlate_fault   (fetch_xlate_fault),
      .operand_xlate_fault (operand_xlate_fault),
      .operand_misaligned  (operand_misaligned),
      .operand_valid       (operand_valid),
      .operand_addr        (operand_addr),
      .watch_address_reg   (r_reg.watch),
      .watch_enable        (r_reg.watch_en),
      .float_exception     (float_exception),
      .float_trap_allow    (r_reg.fstat[`TES_FS_ALLOW]),
      .cause               (cause)
   );

   assign any_trap = |cause;
   assign any_flag = |r_reg.status[`TES_ST_FLOAT:`TES_ST_OPC] || r_reg.ext[`TES_EX_LOCKED];

   always_comb begin
      logic [31:0] m;
      logic [31:0] wv;
      logic [11:0] ra;
      logic        lone_oper;
      m         = '0;
      wv        = '0;
      ra        = '0;
      lone_oper = 1'b0;
      r_next    = r_reg;
      r_next.fetch = 1'b0;
      r_next.abort = 1'b0;
      r_next.complete_fh = 1'b0;
      if (overflow_set) begin
         r_next.ext[`TES_EX_OVF] = 1'b1;
      end
      r_next.hold_n = r_reg.state == tes_pkg::TES_RUN ? !bus_hold_req : 1'b1;
      r_next.status[`TES_ST_SKIPF] = r_reg.status[`TES_ST_SKIPF];

      case (r_reg.state)
         tes_pkg::TES_RUN: begin
            if (any_trap) begin
               r_next.abort       = 1'b1;
               r_next.pend        = cause;
               r_next.pend_dual   = dual_mode;
               r_next.pend_toggle = dual_mode != next_dual;
               r_next.pend_addr   = instr_addr;
               lone_oper = dual_mode && cause == tes_pkg::tes_cause_t'(7'b0001000);
               // Float half retires before entry when the data fault stands alone
               r_next.complete_fh = lone_oper && !float_half_done;
               r_next.state       = tes_pkg::TES_ABORT;
            end
         end
         tes_pkg::TES_ABORT: begin
            r_next.state = tes_pkg::TES_SAVE;
         end
         tes_pkg::TES_SAVE: begin
            r_next.status[`TES_ST_SPRIV]  = r_reg.status[`TES_ST_PRIV];
            r_next.status[`TES_ST_SIRQ]   = r_reg.status[`TES_ST_IRQ];
            r_next.status[`TES_ST_PRIV]   = 1'b0;
            r_next.status[`TES_ST_IRQ]    = 1'b0;
            r_next.status[`TES_ST_DUALT]  = r_reg.pend_dual;
            r_next.status[`TES_ST_TOGGLE] = r_reg.pend_toggle;
            // Flags accumulate, never overwrite earlier ones
            r_next.status[`TES_ST_OPC]   = r_reg.status[`TES_ST_OPC] | r_reg.pend[6];
            r_next.status[`TES_ST_EXT]   = r_reg.status[`TES_ST_EXT] | r_reg.pend[5];
            r_next.status[`TES_ST_FETCH] = r_reg.status[`TES_ST_FETCH] | r_reg.pend[4];
            r_next.status[`TES_ST_OPER]  = r_reg.status[`TES_ST_OPER] | r_reg.pend[3];
            r_next.status[`TES_ST_FLOAT] = r_reg.status[`TES_ST_FLOAT] | r_reg.pend[2];
            r_next.ext[`TES_EX_LOCKED]   = r_reg.ext[`TES_EX_LOCKED] | r_reg.pend[1];
            r_next.ext[`TES_EX_OVF]      = r_next.ext[`TES_EX_OVF] | r_reg.pend[0];
            if (r_reg.pend_dual) begin
               r_next.status[`TES_ST_SKIPF] = r_reg.pend[3] && r_reg.pend[6:4] == 3'b000
                  && r_reg.pend[2:0] == 3'b000;
            end
            if (r_reg.fault_armed) begin
               r_next.fault       = r_reg.pend_addr;
               r_next.fault_armed = 1'b0;
            end
            r_next.entry  = r_reg.pend_addr + (r_reg.pend_dual ? `TES_HALF_STEP : 32'h00000000);
            r_next.hold_n = 1'b1;
            r_next.state  = tes_pkg::TES_FETCH;
         end
         tes_pkg::TES_FETCH: begin
            r_next.fetch  = 1'b1;
            r_next.faddr  = `TES_HANDLER_VA;
            r_next.single = 1'b1;
            r_next.state  = tes_pkg::TES_RUN;
         end
         default: r_next.state = tes_pkg::TES_RUN;
      endcase
      if (r_reg.state == tes_pkg::TES_RUN && dual_mode) begin
         r_next.single = 1'b0;
      end

      r_next.tbr  = any_flag;
      r_next.kill = r_reg.status[`TES_ST_SKIPF] && float_issue;
      r_next.user = r_next.status[`TES_ST_PRIV];

      // Write channel
      if (s_axi_awvalid && r_reg.awr) begin
         r_next.awaddr = s_axi_awaddr;
         r_next.aw_got = 1'b1;
         r_next.awr    = 1'b0;
      end
      if (s_axi_wvalid && r_reg.wr) begin
         r_next.wdata = s_axi_wdata;
         r_next.wstrb = s_axi_wstrb;
         r_next.w_got = 1'b1;
         r_next.wr    = 1'b0;
      end
      if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
         for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{r_reg.wstrb[i]}};
         end
         r_next.bresp = 2'b00;
         if (r_reg.awaddr == `TES_OFF_STATUS) begin
            wv = (r_reg.status & ~m) | (r_reg.wdata & m);
            // Bits hardware sets in the same cycle win over software; hardware clears do not
            r_next.status = (wv & `TES_ST_MASK) | (r_next.status & ~r_reg.status & `TES_ST_MASK);
         end else if (r_reg.awaddr == `TES_OFF_EXT) begin
            wv = (r_reg.ext & ~m) | (r_reg.wdata & m);
            r_next.ext = (wv & `TES_EX_MASK) | (r_next.ext & ~r_reg.ext);
         end else if (r_reg.awaddr == `TES_OFF_FSTAT) begin
            r_next.fstat = ((r_reg.fstat & ~m) | (r_reg.wdata & m)) & 32'h00000001;
         end else if (r_reg.awaddr == `TES_OFF_WATCH) begin
            r_next.watch = (r_reg.watch & ~m) | (r_reg.wdata & m);
         end else if (r_reg.awaddr == `TES_OFF_CTRL) begin
            if (r_reg.wstrb[0]) begin
               r_next.watch_en = r_reg.wdata[0];
            end
         end else if (r_reg.awaddr != `TES_OFF_FAULT && r_reg.awaddr != `TES_OFF_ENTRY) begin
            r_next.bresp = 2'b10;
         end
         r_next.bvalid = 1'b1;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
         r_next.aw_got = 1'b0;
         r_next.w_got  = 1'b0;
         r_next.awr    = 1'b1;
         r_next.wr     = 1'b1;
      end

      // Read channel
      if (s_axi_arvalid && r_reg.arr) begin
         ra = s_axi_araddr;
         r_next.arr    = 1'b0;
         r_next.rvalid = 1'b1;
         r_next.rresp  = 2'b00;
         if (ra == `TES_OFF_STATUS) begin
            r_next.rdata = r_reg.status;
         end else if (ra == `TES_OFF_EXT) begin
            r_next.rdata = r_reg.ext;
         end else if (ra == `TES_OFF_FAULT) begin
            r_next.rdata = r_reg.fault;
            // Re-arms capture, unless a capture lands now: that address is still unread
            if (r_reg.state != tes_pkg::TES_SAVE || !r_reg.fault_armed) begin
               r_next.fault_armed = 1'b1;
            end
         end else if (ra == `TES_OFF_FSTAT) begin
            r_next.rdata = r_reg.fstat;
         end else if (ra == `TES_OFF_ENTRY) begin
            r_next.rdata = r_reg.entry;
         end else if (ra == `TES_OFF_WATCH) begin
            r_next.rdata = r_reg.watch;
         end else if (ra == `TES_OFF_CTRL) begin
            r_next.rdata = {31'h00000000, r_reg.watch_en};
         end else begin
            r_next.rdata = 32'h00000000;
            r_next.rresp = 2'b10;
         end
      end
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
         r_next.arr    = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg             <= '0;
         r_reg.state       <= tes_pkg::TES_RUN;
         r_reg.status      <= `TES_RST_STATUS;
         r_reg.fstat       <= `TES_RST_FSTAT;
         r_reg.fault_armed <= 1'b1;
         r_reg.hold_n      <= 1'b1;
         r_reg.single      <= 1'b1;
         r_reg.user        <= 1'b1;
         r_reg.awr         <= 1'b1;
         r_reg.wr          <= 1'b1;
         r_reg.arr         <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign abort_instr         = r_reg.abort;
   assign complete_float_half = r_reg.complete_fh;
   assign fetch_req           = r_reg.fetch;
   assign fetch_addr          = r_reg.faddr;
   assign single_mode_force   = r_reg.single;
   assign trap_branch_mode    = r_reg.tbr;
   assign kill_float          = r_reg.kill;
   assign bus_hold_n          = r_reg.hold_n;
   assign user_mode           = r_reg.user;
   assign s_axi_awready       = r_reg.awr;
   assign s_axi_wready        = r_reg.wr;
   assign s_axi_bresp         = r_reg.bresp;
   assign s_axi_bvalid        = r_reg.bvalid;
   assign s_axi_arready       = r_reg.arr;
   assign s_axi_rdata         = r_reg.rdata;
   assign s_axi_rresp         = r_reg.rresp;
   assign s_axi_rvalid        = r_reg.rvalid;
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the trap entry sequencer.
// Assumes the software model makes register accesses; trap causes come from here.
`timescale 1ns/1ps
`include "tes_map.svh"
module tb;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic        opcode_cond, overflow_check_op, lock_violation, external_irq_pin, fetch_xlate_fault;
   logic        operand_xlate_fault, operand_misaligned, watch_hit, float_exception, overflow_set;
   logic        dual_mode, next_dual, float_half_done, float_issue;
   logic        operand_valid = 1'h1;
   logic        bus_hold_req = 1'h1;
   logic        indirect_branch = 1'h0;
   logic [31:0] instr_addr, watch, operand_addr, fetch_addr, lf, fa;
   logic        abort_instr, complete_float_half, fetch_req, single_mode_force, trap_branch_mode;
   logic        kill_float, bus_hold_n, user_mode;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [33:0] q[$];
   logic        armed = 1'h1;
   int          errors = 0;
   int          num_checks = 0;
   int          na = 0;
   int          nk = 0;
   int          nc = 0;
   logic [4:0]  fb [9] = '{5'h01, 5'h01, 5'h01, 5'h02, 5'h04, 5'h08, 5'h08, 5'h08, 5'h10};
   logic [1:0]  xb [9] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

   initial {opcode_cond, overflow_check_op, lock_violation, external_irq_pin, fetch_xlate_fault,
            operand_xlate_fault, operand_misaligned, watch_hit, float_exception, overflow_set,
            dual_mode, next_dual, float_half_done, float_issue, instr_addr, watch} = '0;
   assign operand_addr = watch_hit ? watch : ~watch;
   always #20 aclk = ~aclk;

   tes_sequencer dut (.*);
   tes_sw_model u_sw (.*);

   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Read results are compared where they appear, oldest note first
   always @(posedge aclk) begin
      na <= na + 32'(abort_instr);
      nk <= nk + 32'(kill_float);
      nc <= nc + 32'(complete_float_half);
      if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, q.pop_front());
   end
   task automatic chk(input logic [11:0] a, input logic [31:0] e);
      q.push_back({2'h0, e});
      u_sw.rd(a);
   endtask
   task automatic setc(input logic [8:0] v);
      {float_exception, watch_hit, operand_misaligned, operand_xlate_fault, fetch_xlate_fault,
       external_irq_pin, lock_violation, overflow_check_op, opcode_cond} <= v;
   endtask
   task automatic pulse_float;
      @(posedge aclk);
      float_issue <= 1'h1;
      @(posedge aclk);
      float_issue <= 1'h0;
   endtask
   task automatic notrap(input logic [8:0] v);
      int n0;
      n0 = na;
      @(posedge aclk);
      setc(v);
      @(posedge aclk);
      setc(9'h000);
      repeat (6) @(posedge aclk);
      cmp(34'(na - n0), 34'h0);
   endtask
   // Status before every trap is user mode with interrupts on (0x5)
   task automatic trap(input logic [8:0] v, input logic [4:0] fl, input logic [1:0] ex, input logic rdf);
      int n0;
      int k0;
      int t;
      int c0;
      logic sk;
      n0 = na;
      k0 = nk;
      c0 = nc;
      lf = nx(lf);
      if (v[1]) begin
         @(posedge aclk) overflow_set <= 1'h1;
         @(posedge aclk) overflow_set <= 1'h0;
      end
      @(posedge aclk);
      instr_addr <= {lf[31:3], 3'h0};
      setc(v);
      @(posedge aclk);
      setc(9'h000);
      if (armed) fa = instr_addr;
      t = 0;
      while (!fetch_req && t < 12) begin
         @(posedge aclk);
         t++;
      end
      cmp({1'h0, fetch_req, fetch_addr}, {2'h1, `TES_HANDLER_VA});
      sk = dual_mode && fl == 5'h08 && ex == 2'h0;
      chk(`TES_OFF_STATUS, {19'h0, fl, 1'h0, sk, dual_mode ^ next_dual, dual_mode, 4'hA});
      chk(`TES_OFF_EXT, {30'h0, ex});
      if (rdf) chk(`TES_OFF_FAULT, fa);
      armed = rdf;
      if (dual_mode) chk(`TES_OFF_ENTRY, fa + `TES_HALF_STEP);
      pulse_float;
      u_sw.ret(32'h5);
      pulse_float;
      repeat (2) @(posedge aclk);
      cmp(34'(nk - k0), 34'(sk));
      cmp(34'(nc - c0), 34'(sk && !float_half_done));
      cmp(34'(na - n0), 34'h1);
      cmp({32'h0, trap_branch_mode, user_mode}, 34'h1);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      lf = 32'h82B8;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      chk(`TES_OFF_STATUS, `TES_RST_STATUS);
      chk(`TES_OFF_FSTAT, `TES_RST_FSTAT);
      q.push_back(34'h200000000);
      u_sw.rd(12'h100);
      u_sw.wr(12'h100, 32'h1, r);
      cmp({32'h0, r}, 34'h2);
      u_sw.wr(`TES_OFF_FAULT, 32'hFFFF, r);
      chk(`TES_OFF_FAULT, 32'h0);
      notrap(9'h008);
      lf = nx(lf);
      watch <= lf;
      u_sw.wr(`TES_OFF_WATCH, lf, r);
      u_sw.wr(`TES_OFF_CTRL, 32'h1, r);
      u_sw.wr(`TES_OFF_FSTAT, 32'h0, r);
      notrap(9'h100);
      u_sw.wr(`TES_OFF_FSTAT, 32'h1, r);
      u_sw.wr(`TES_OFF_STATUS, 32'h5, r);
      for (int i = 0; i < 9; i++) begin
         lf = nx(lf);
         dual_mode <= lf[0];
         next_dual <= lf[1];
         float_half_done <= lf[2];
         trap(9'h001 << i, fb[i], xb[i], 1'h1);
      end
      trap(9'h011, 5'h05, 2'h0, 1'h1);
      dual_mode <= 1'h1;
      next_dual <= 1'h1;
      float_half_done <= 1'h0;
      trap(9'h040, 5'h08, 2'h0, 1'h1);
      dual_mode <= 1'h0;
      trap(9'h001, 5'h01, 2'h0, 1'h0);
      trap(9'h010, 5'h04, 2'h0, 1'h1);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      tally_and_finish();
   end
endmodule

bind tes_sequencer tes_sequencer_asserts u_chk (
   .aclk                (aclk),
   .aresetn             (aresetn),
   .float_issue         (float_issue),
   .abort_instr         (abort_instr),
   .complete_float_half (complete_float_half),
   .fetch_req           (fetch_req),
   .fetch_addr          (fetch_addr),
   .single_mode_force   (single_mode_force),
   .trap_branch_mode    (trap_branch_mode),
   .kill_float          (kill_float),
   .bus_hold_n          (bus_hold_n),
   .user_mode           (user_mode)
);

// ---- sim/tes_sequencer_asserts.sv ----
// Port checker for the trap entry sequencer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tes_sequencer_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        float_issue,
   input wire logic        abort_instr,
   input wire logic        complete_float_half,
   input wire logic        fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic        single_mode_force,
   input wire logic        trap_branch_mode,
   input wire logic        kill_float,
   input wire logic        bus_hold_n,
   input wire logic        user_mode
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_release;
      ##2 bus_hold_n;
   endsequence
   sequence s_vector;
      fetch_req && fetch_addr == 32'hFFFFFF00;
   endsequence
   a_entry_steps: assert property (abort_instr |-> s_release ##1 s_vector)
      else $error("entry did not release bus and vector");
   a_fetch_cause: assert property (fetch_req |-> $past(abort_instr, 3))
      else $error("handler fetch without entry");
   a_abort_gap: assert property (abort_instr |=> !abort_instr [*3])
      else $error("abort during entry");
   a_super_mode: assert property (abort_instr |-> ##3 !user_mode)
      else $error("user mode kept after entry");
   a_single_run: assert property (fetch_req |-> single_mode_force)
      else $error("handler fetch not single mode");
   a_float_half: assert property (complete_float_half |-> abort_instr)
      else $error("float half completion outside entry");
   a_kill_cause: assert property (kill_float |-> $past(float_issue))
      else $error("float kill without issue");
   a_branch_mode: assert property (abort_instr |-> ##3 trap_branch_mode)
      else $error("trap branch mode missing");
endmodule

// ---- sim/tes_sw_model.sv ----
// Software handler model: register master for the handler's accesses.
// Assumes an AXI4-Lite slave on aclk; read data is watched by the bench.
`timescale 1ns/1ps
`include "tes_map.svh"
module tes_sw_model (
   input  wire logic        aclk,
   output logic [11:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [11:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'h0;
            r = s_axi_bresp;
            break;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'h0;
            break;
         end
      end
   endtask
   // Handler exit: float trap allow cleared and set again, then ext cleared and status restored
   task automatic ret(input logic [31:0] st);
      logic [1:0] r;
      wr(`TES_OFF_FSTAT, 32'h0, r);
      wr(`TES_OFF_FSTAT, 32'h1, r);
      wr(`TES_OFF_EXT, 32'h0, r);
      wr(`TES_OFF_STATUS, st, r);
   endtask
endmodule
